// ### design/host_parallel_bus_port.sv
// Host controller that drives a framer's asynchronous parallel port.
// Assumes pins sampled on pclk and software reaching it over APB.
// Summary of operation
// (R1) Multiplexed bus: drive address on data lines, drop latch strobe.
// (R2) Demultiplexed bus: hold the latch strobe high.
// (R3) Separate strobes: read strobe with chip select reads addressed data.
// (R4) Separate strobes: write strobe with chip select writes bus data.
// (R5) Data-strobe protocol: data strobe times each access.
// (R6) Data-strobe protocol: direction pin tells read from write.
// (R7) Narrow bus uses the low eight data lines; upper lines idle high.
// (R8) Wide bus allows full sixteen-bit word transfers.
// (R9) Byte lane chosen by address bit zero, lane enable and protocol.
// (R10) Unused data half is pulled high during byte transfers.
// (R11) Protocol strap low selects separate strobes, high data strobe.
// (R12) Device answers only while chip select is low.
// (R13) Separate strobes, wide bus: upper lane enable marks high byte.
// (R14) Data strobe, wide bus: lower lane enable marks low byte.
// (R15) Narrow bus: lane enable has no effect, held high.
// (R16) One shared interrupt request output from the device.
// (R17) Masked sources never assert the interrupt output.
// (R18) Pending interrupts reported through readable status registers.
// (R19) Interrupt pin style is programmed in the device.
// (R20) Eight address bits select exactly one device register.
// (R21) Device data drivers stay off outside read accesses.
// (R22) Direction high means read, low means write.
`timescale 1ns/1ps
`default_nettype none
module host_parallel_bus_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  addr_out,
  output logic             addr_latch,
  output logic             chip_sel_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic             upper_lane_en,
  output logic             bus_width_strap,
  output logic             bus_protocol_strap,
  output logic      [15:0] data_out,
  output logic      [15:0] data_oe,
  input  wire logic [15:0] data_in,
  input  wire logic        irq_in
);
  // In data-strobe protocol read_strobe_n is data_strobe_n, write_strobe_n
  // is the direction pin and upper_lane_en acts as lower_lane_en.
  hpb_pkg::state_t st_r, st_nxt;
  logic [6:0]  ctrl_r;
  logic [7:0]  addr_r, timing_r, cnt_r;
  logic [15:0] wdata_r, rdata_r;
  logic        done_r, irq_r;

  wire acc       = psel & penable;
  wire wr_acc    = acc & pwrite;
  // A write refused at its setup edge stays refused at its access edge.
  wire wr_ok     = wr_acc & ~pslverr;
  wire busy      = (st_r != hpb_pkg::ST_IDLE);
  wire go        = wr_ok & (paddr == hpb_pkg::CTRL_OFS) &
                   pwdata[hpb_pkg::CTRL_GO_BIT];
  wire rd_op     = ctrl_r[hpb_pkg::CTRL_RD_BIT];
  wire [1:0] lane = ctrl_r[hpb_pkg::CTRL_LANE_LSB +: 2];
  wire mux_mode  = ctrl_r[hpb_pkg::CTRL_MUX_BIT];
  wire proto     = ctrl_r[hpb_pkg::CTRL_PROTO_BIT];
  wire wide      = ctrl_r[hpb_pkg::CTRL_WIDE_BIT];
  wire cnt_done  = (cnt_r == 8'h00);
  wire [7:0] phase_len = (timing_r < 8'(hpb_pkg::MIN_PHASE_CYC)) ?
                         8'(hpb_pkg::MIN_PHASE_CYC) : timing_r;
  // Byte-lane selection; narrow bus ignores lane and A0. [R9] [R15]
  wire lo_act = ~wide | (lane != hpb_pkg::LANE_HIGH);
  wire hi_act = wide & (lane != hpb_pkg::LANE_LOW);
  // Lane enable is active low in both protocols. [R13] [R14]
  wire lane_n = ~wide ? 1'b1 :
                proto ? ~lo_act : ~hi_act;
  wire [15:0] wr_bus = {hi_act ? wdata_r[15:8] : 8'hFF,
                        lo_act ? wdata_r[7:0] : 8'hFF}; // [R10]
  wire [15:0] rd_cap = {hi_act ? data_in[15:8] : 8'hFF, data_in[7:0]};
  wire [31:0] rd_mux =
    (paddr == hpb_pkg::CTRL_OFS)   ? {25'h0, ctrl_r} :
    (paddr == hpb_pkg::ADDR_OFS)   ? {24'h0, addr_r} :
    (paddr == hpb_pkg::WDATA_OFS)  ? {16'h0, wdata_r} :
    (paddr == hpb_pkg::RDATA_OFS)  ? {16'h0, rdata_r} :
    (paddr == hpb_pkg::STATUS_OFS) ? {29'h0, irq_r, done_r, busy} :
    (paddr == hpb_pkg::TIMING_OFS) ? {24'h0, timing_r} : 32'h0;
  wire mapped = (paddr <= hpb_pkg::TIMING_OFS) & (paddr[1:0] == 2'h0);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      hpb_pkg::ST_IDLE:   if (go) st_nxt = hpb_pkg::ST_ADDR;
      hpb_pkg::ST_ADDR:   if (cnt_done) st_nxt = hpb_pkg::ST_LATCH;
      hpb_pkg::ST_LATCH:  if (cnt_done) st_nxt = hpb_pkg::ST_STROBE;
      hpb_pkg::ST_STROBE: if (cnt_done) st_nxt = hpb_pkg::ST_HOLD;
      hpb_pkg::ST_HOLD:   if (cnt_done) st_nxt = hpb_pkg::ST_IDLE;
      default:            st_nxt = hpb_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= hpb_pkg::ST_IDLE;
      cnt_r <= 8'h00;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= (st_nxt != st_r) ? phase_len - 8'h01 :
               (cnt_done ? 8'h00 : cnt_r - 8'h01);
    end
  end

  // Software registers; APB answers in the access cycle with no wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= hpb_pkg::CTRL_RST;
      addr_r   <= 8'h00;
      wdata_r  <= 16'h0000;
      timing_r <= hpb_pkg::TIMING_RST;
    end else if (wr_ok) begin
      if (paddr == hpb_pkg::CTRL_OFS)   ctrl_r   <= pwdata[6:0];
      if (paddr == hpb_pkg::ADDR_OFS)   addr_r   <= pwdata[7:0];
      if (paddr == hpb_pkg::WDATA_OFS)  wdata_r  <= pwdata[15:0];
      if (paddr == hpb_pkg::TIMING_OFS) timing_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (~mapped | (pwrite & busy));
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // Done is set at end of access; the set wins over a software clear.
  wire done_set = (st_r == hpb_pkg::ST_HOLD) & cnt_done;
  wire done_clr = wr_ok & (paddr == hpb_pkg::STATUS_OFS) &
                  pwdata[hpb_pkg::STAT_DONE_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r  <= 1'b0;
      rdata_r <= 16'h0000;
      irq_r   <= 1'b0;
    end else begin
      done_r <= done_set | (done_r & ~done_clr);
      irq_r  <= ~irq_in; // Active-low request as configured in device. [R16]
      // Sample read data at the end of the strobe phase. [R3] [R7]
      if ((st_r == hpb_pkg::ST_STROBE) & cnt_done & rd_op)
        rdata_r <= rd_cap;
    end
  end

  // Pin drive follows st_nxt so every registered pin lines up with st_r.
  // The address stays on the lines through LATCH, so it is still valid
  // at and after the fall of the latch strobe.
  wire nxt_busy  = (st_nxt != hpb_pkg::ST_IDLE);
  wire addr_hold = mux_mode & (st_nxt == hpb_pkg::ST_ADDR |
                               st_nxt == hpb_pkg::ST_LATCH);  // [R1]
  wire [15:0] oe_nxt =
    addr_hold ? 16'h00FF :
    (nxt_busy & ~rd_op) ? (wide ? 16'hFFFF : 16'h00FF) : 16'h0000; // [R21]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_out           <= 8'h00;
      addr_latch         <= 1'b1;
      chip_sel_n         <= 1'b1;
      read_strobe_n      <= 1'b1;
      write_strobe_n     <= 1'b1;
      upper_lane_en      <= 1'b1;
      bus_width_strap    <= 1'b0;
      bus_protocol_strap <= 1'b0;
      data_out           <= 16'hFFFF;
      data_oe            <= 16'h0000;
    end else begin
      addr_out           <= addr_r;                            // [R20]
      // Latch strobe pulses high in ADDR and falls entering LATCH. [R1][R2]
      addr_latch         <= ~mux_mode | (st_nxt == hpb_pkg::ST_ADDR);
      chip_sel_n         <= ~(st_nxt == hpb_pkg::ST_LATCH |
                              st_nxt == hpb_pkg::ST_STROBE |
                              st_nxt == hpb_pkg::ST_HOLD);     // [R12]
      read_strobe_n      <= proto ? ~(st_nxt == hpb_pkg::ST_STROBE) // [R5]
                            : ~(st_nxt == hpb_pkg::ST_STROBE & rd_op); // [R3]
      write_strobe_n     <= proto ? rd_op                      // [R6] [R22]
                            : ~(st_nxt == hpb_pkg::ST_STROBE & ~rd_op); // [R4]
      upper_lane_en      <= lane_n;                 // [R13] [R14] [R15]
      bus_width_strap    <= wide;                   // [R8]
      bus_protocol_strap <= proto;                  // [R11]
      data_out           <= addr_hold ? {8'hFF, addr_r} : wr_bus;
      data_oe            <= oe_nxt;
    end
  end
  a_strobe_cs: assert property (@(posedge pclk) disable iff (!presetn)
    !read_strobe_n |-> !chip_sel_n)
    else $error("read strobe without chip select"); // [R12]
  a_wr_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (!write_strobe_n && !proto) |-> (data_oe != 16'h0000))
    else $error("write strobe with bus undriven"); // [R4]
  a_rd_release: assert property (@(posedge pclk) disable iff (!presetn)
    (!read_strobe_n && !proto) |-> (data_oe == 16'h0000))
    else $error("host drives bus during read"); // [R21]
  a_latch_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(addr_latch) |-> (data_oe == 16'h00FF && data_out[7:0] == addr_r))
    else $error("address not on bus at latch fall"); // [R1]
  a_demux_ale: assert property (@(posedge pclk) disable iff (!presetn)
    (!mux_mode && busy && $past(busy)) |-> addr_latch)
    else $error("latch strobe low on demux bus"); // [R2]
  a_narrow_lane: assert property (@(posedge pclk) disable iff (!presetn)
    (!wide && busy && $past(busy)) |-> upper_lane_en)
    else $error("lane enable low on narrow bus"); // [R15]
  a_done_after: assert property (@(posedge pclk) disable iff (!presetn)
    done_set |=> done_r)
    else $error("done flag not set"); // [R3]
  a_ds_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (proto && !read_strobe_n) |-> (write_strobe_n == rd_op))
    else $error("direction wrong during data strobe"); // [R22]
endmodule // host_parallel_bus_port
`default_nettype wire

// ### design/hpb_pkg.sv
// Package for the host-side parallel bus controller.
// Assumes a single 250 MHz pclk domain and an APB register port.
package hpb_pkg;
  // Own register offsets (byte addresses).
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] ADDR_OFS    = 8'h04;
  localparam logic [7:0] WDATA_OFS   = 8'h08;
  localparam logic [7:0] RDATA_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS  = 8'h10;
  localparam logic [7:0] TIMING_OFS  = 8'h14;
  // CTRL fields.
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_RD_BIT    = 1;
  localparam int CTRL_LANE_LSB  = 2;
  localparam int CTRL_MUX_BIT   = 4;
  localparam int CTRL_PROTO_BIT = 5;
  localparam int CTRL_WIDE_BIT  = 6;
  // STATUS fields.
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_IRQ_BIT   = 2;
  // Lane codes in CTRL: both lanes, low byte only, high byte only.
  localparam logic [1:0] LANE_WORD = 2'h0;
  localparam logic [1:0] LANE_LOW  = 2'h1;
  localparam logic [1:0] LANE_HIGH = 2'h2;
  // Reset values.
  localparam logic [6:0] CTRL_RST   = 7'h00;
  localparam logic [7:0] TIMING_RST = 8'h04;
  // Least strobe phase time, in ns, and its cycle count at 250 MHz.
  localparam int PCLK_MHZ     = 250;
  localparam int MIN_PHASE_NS = 16;
  localparam int MIN_PHASE_CYC = (MIN_PHASE_NS * PCLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDR   = 3'h1,
    ST_LATCH  = 3'h3,
    ST_STROBE = 3'h2,
    ST_HOLD   = 3'h6
  } state_t;
endpackage

// ### verification/dev_model.sv
// Behavioural model of the framer's parallel host port on the far side.
// Assumes the bench resolves the shared data lines, pulled high when idle.
`timescale 1ns/1ps
`default_nettype none
module dev_model (
  input  wire logic [7:0]  a_pin,
  input  wire logic        ale,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        lane_n,
  input  wire logic        wide,
  input  wire logic        proto,
  input  wire logic [15:0] bus,
  input  wire logic        pend,
  output logic      [15:0] drv_oe,
  output logic      [15:0] drv,
  output logic             irq_n
);
  logic [15:0] mem [256];
  logic [7:0]  lat;
  always @(negedge ale) lat <= bus[7:0];
  // With the latch strobe held high the address pins are used directly.
  wire [7:0] a  = ale ? a_pin : lat;
  wire ds = !cs_n && !rd_n;
  wire rd = proto ? ds && wr_n : ds;
  wire wr = proto ? ds && !wr_n : !cs_n && !wr_n;
  wire hi = wide && (proto ? !a[0] : !lane_n);
  wire lo = !wide || (proto ? !lane_n : !a[0]);
  always @(bus or wr or a or hi or lo) begin
    if (wr && hi) mem[a][15:8] = bus[15:8];
    if (wr && lo) mem[a][7:0] = bus[7:0];
  end
  // Lanes not driven fall to the pull-up level in the bench.
  assign drv = mem[a];
  assign drv_oe = {{8{rd && hi}}, {8{rd && lo}}};
  // Push-pull active low, every source unmasked.
  assign irq_n = !pend;
endmodule // dev_model
`default_nettype wire

// ### verification/host_parallel_bus_port_tb.sv
// Self-checking bench for the host parallel bus controller.
// Assumes the device model on the far side and APB from the bench.
`timescale 1ns/1ps
`default_nettype none
module host_parallel_bus_port_tb;
  logic        pclk, presetn, psel, penable, pwrite, pend, err;
  logic        pready, pslverr, addr_latch, chip_sel_n, irq_in;
  logic        read_strobe_n, write_strobe_n, upper_lane_en;
  logic        bus_width_strap, bus_protocol_strap;
  logic [7:0]  paddr, addr_out, a;
  logic [31:0] pwdata, prdata, rd, d, c, m;
  logic [15:0] data_out, data_oe, data_in, drv, drv_oe;
  int          fail_count, n_checks, k;
  assign data_in = (data_oe & data_out) | (~data_oe & drv_oe & drv)
                 | (~data_oe & ~drv_oe);
  host_parallel_bus_port u_host_parallel_bus_port (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .addr_out, .addr_latch, .chip_sel_n, .read_strobe_n, .write_strobe_n,
    .upper_lane_en, .bus_width_strap, .bus_protocol_strap, .data_out,
    .data_oe, .data_in, .irq_in);
  dev_model u_dev_model (.a_pin(addr_out), .ale(addr_latch),
    .cs_n(chip_sel_n), .rd_n(read_strobe_n), .wr_n(write_strobe_n),
    .lane_n(upper_lane_en), .wide(bus_width_strap),
    .proto(bus_protocol_strap), .bus(data_in), .pend(pend),
    .drv_oe(drv_oe), .drv(drv), .irq_n(irq_in));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin fail_count++; complete_run(); end
  endtask
  // Polls until idle with done set, then clears done.
  task automatic wait_done;
    int i;
    for (i = 0; i < 40; i++) begin
      apb(1'b0, hpb_pkg::STATUS_OFS, 32'h0);
      if (rd[1:0] === 2'b10) break;
    end
    if (i == 40) begin fail_count++; complete_run(); end
    apb(1'b1, hpb_pkg::STATUS_OFS, 32'h2);
  endtask
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pend = 0;
    presetn = 0; fail_count = 0; n_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk("cs idle", 32'h1, {31'h0, chip_sel_n});
    chk("latch idle", 32'h1, {31'h0, addr_latch});
    apb(1'b0, hpb_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, hpb_pkg::TIMING_OFS, 32'h0);
    chk("timing", 32'h4, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test registers finished");
    // Every mix of mux, protocol and width: write, then read back.
    for (k = 0; k < 8; k++) begin
      a = 8'h30 + 8'(k * 2);
      d = 32'h0000C35A + 32'h00000103 * k;
      c = {25'h0, 3'(k), 4'h1};
      m = k[2] ? 32'hFFFF : 32'h00FF;
      apb(1'b1, hpb_pkg::ADDR_OFS, {24'h0, a});
      apb(1'b1, hpb_pkg::WDATA_OFS, d);
      apb(1'b1, hpb_pkg::CTRL_OFS, c);
      apb(1'b1, hpb_pkg::WDATA_OFS, 32'h0);
      chk("busy refusal", 32'h1, {31'h0, err});
      wait_done();
      chk("width strap", 32'(k[2]), {31'h0, bus_width_strap});
      chk("proto strap", 32'(k[1]), {31'h0, bus_protocol_strap});
      chk("stored", d & m, {16'h0, u_dev_model.mem[a]} & m);
      apb(1'b1, hpb_pkg::CTRL_OFS, c | 32'h2);
      wait_done();
      apb(1'b0, hpb_pkg::RDATA_OFS, 32'h0);
      chk("read back", d & m, rd & m);
      chk("oe idle", 32'h0, {16'h0, data_oe});
      chk("cs after", 32'h1, {31'h0, chip_sel_n});
    end
    $display("test transfers finished");
    // Byte lanes on the wide bus, one per protocol; the idle half reads high.
    a = 8'h50;
    apb(1'b1, hpb_pkg::ADDR_OFS, {24'h0, a});
    apb(1'b1, hpb_pkg::WDATA_OFS, 32'h1234);
    apb(1'b1, hpb_pkg::CTRL_OFS, 32'h41);
    wait_done();
    apb(1'b1, hpb_pkg::WDATA_OFS, 32'hABCD);
    apb(1'b1, hpb_pkg::CTRL_OFS, 32'h45);
    wait_done();
    chk("low lane write", 32'h12CD, {16'h0, u_dev_model.mem[a]});
    apb(1'b1, hpb_pkg::CTRL_OFS, 32'h47);
    wait_done();
    apb(1'b0, hpb_pkg::RDATA_OFS, 32'h0);
    chk("low lane read", 32'hFFCD, rd);
    apb(1'b1, hpb_pkg::WDATA_OFS, 32'h5678);
    apb(1'b1, hpb_pkg::CTRL_OFS, 32'h69);
    wait_done();
    chk("high lane write", 32'h56CD, {16'h0, u_dev_model.mem[a]});
    apb(1'b1, hpb_pkg::CTRL_OFS, 32'h6B);
    wait_done();
    apb(1'b0, hpb_pkg::RDATA_OFS, 32'h0);
    chk("high lane read", 32'h56FF, rd);
    $display("test byte lanes finished");
    pend <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, hpb_pkg::STATUS_OFS, 32'h0);
    chk("irq set", 32'h1, {31'h0, rd[2]});
    pend <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, hpb_pkg::STATUS_OFS, 32'h0);
    chk("irq clear", 32'h0, {31'h0, rd[2]});
    $display("test interrupt finished");
    complete_run();
  end
endmodule // host_parallel_bus_port_tb
`default_nettype wire
